/* dv/bus_partner.sv */
// resolves the four local bus wires seen by the cell
// assumes cell and far drivers are levels; an undriven wire keeps no value
module bus_partner (
    input  wire logic       ref_clk_in,
    input  wire logic [3:0] cell_val_in,
    input  wire logic [3:0] cell_oe_in,
    input  wire logic [3:0] ext_val_in,
    input  wire logic [3:0] ext_oe_in,
    output logic      [3:0] bus_level_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] last = 4'h0;   // known start so a released wire really toggles
    // remember the wire so a released bus flips every cycle
    always_ff @(posedge ref_clk_in) begin
        last <= bus_level_out;
    end
    // cell drive wins, then a far driver, else a changing level
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            bus_level_out[i] = cell_oe_in[i] ? cell_val_in[i] :
                               ext_oe_in[i] ? ext_val_in[i] : ~last[i];
        end
    end
endmodule : bus_partner

/* dv/tb_top.sv */
// self-checking bench for the array cell, inputs set on rising edges
// assumes registered outputs, one cycle behind the inputs
module tb_top;
    import pac_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in = 0, nrst_in = 0, drive_mode_in = 0, express_clock_in = 0;
    logic global_clock_level_in = 0, head_first_in = 0, global_reset_n_in = 1;
    logic express_reset_n_in = 1, foot_first_n_in = 1, reg_state_out;
    logic corner_west_first_input_out, corner_north_first_input_out;
    logic [2:0] first_sel_in = 4, second_sel_in = 4;
    logic [1:0] tap_sel_in = 0, func_state_in = 0, turn_en_in = 0, turn_dir_in = 0;
    logic [1:0] clk_src_sel_in = 3, rst_src_sel_in = 3;
    logic [3:0] first_class_in = 0, second_class_in = 0, bus_read_en_in = 0;
    logic [3:0] bus_write_en_in = 0, driver_pass_en_in = 0, rep_bidir_en_in = 0;
    logic [3:0] exp_a_in = 0, exp_b_in = 0, seg_b_in = 0, seg_b_active_in = 0;
    logic [3:0] ext_val = 0, ext_oe = 0, bus_in, first_class_out, second_class_out;
    logic [3:0] bus_out, bus_oe_out, bus_fault_out, rep_local_out, rep_local_oe_out;
    logic [3:0] seg_b_out, seg_b_oe_out, exp_a_out, exp_a_oe_out, exp_b_out, exp_b_oe_out;
    logic [3:0][4:0] rep_func_in = 0;
    logic [3:0] ea, eb;
    int err_total = 0, check_count = 0, cycles = 0;
    programmable_array_cell i_programmable_array_cell (.*);
    bus_partner i_bus_partner (.ref_clk_in(ref_clk_in), .cell_val_in(bus_out),
        .cell_oe_in(bus_oe_out), .ext_val_in(ext_val), .ext_oe_in(ext_oe),
        .bus_level_out(bus_in));
    // free-running clock and hang guard
    always #2 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // let n edges pass, then look at settled outputs
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask : tick
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    // main sequence
    initial begin
        tick(1);
        chk("reset first", 4'h0, first_class_out);
        @(posedge ref_clk_in); nrst_in <= 1;
        tick(1);
        chk("const one", 4'hF, first_class_out);
        chk("const one b", 4'hF, second_class_out);
        // neighbour picks and the three combinational states
        for (int f = 0; f < 3; f++) begin
            for (int v = 0; v < 4; v++) begin
                @(posedge ref_clk_in);
                func_state_in <= f[1:0]; first_sel_in <= 3; second_sel_in <= 1;
                first_class_in <= {v[1], 3'h0}; second_class_in <= {2'h0, v[0], 1'h0};
                tick(1);
                ea = {4{f == 0 ? v[1] : f == 1 ? v[0] : v[1] ^ v[0]}};
                eb = {4{f == 0 ? v[0] : f == 1 ? v[1] : ~(v[1] & v[0])}};
                chk("state a", ea, first_class_out);
                chk("state b", eb, second_class_out);
            end
        end
        // registered state on the global tick, stopped clock, express edge and column reset
        @(posedge ref_clk_in);
        func_state_in <= FUNC_REG_AND; clk_src_sel_in <= SRC_GLOBAL;
        first_class_in <= 4'h8; second_class_in <= 4'h0;
        tick(3);
        chk("flop", 4'h1, {3'h0, reg_state_out});
        chk("flop a", 4'hF, first_class_out);
        @(posedge ref_clk_in); clk_src_sel_in <= SRC_ONE; second_class_in <= 4'h2;
        tick(3);
        chk("no clock", 4'h1, {3'h0, reg_state_out});
        chk("and b", 4'hF, second_class_out);
        @(posedge ref_clk_in); clk_src_sel_in <= SRC_EXPRESS;
        tick(2);
        chk("express low", 4'h1, {3'h0, reg_state_out});
        @(posedge ref_clk_in); express_clock_in <= 1;
        tick(3);
        chk("express edge", 4'h0, {3'h0, reg_state_out});
        @(posedge ref_clk_in); clk_src_sel_in <= SRC_GLOBAL; second_class_in <= 4'h0;
        tick(3);
        @(posedge ref_clk_in); rst_src_sel_in <= SRC_GLOBAL; global_reset_n_in <= 0;
        tick(2);
        chk("column reset", 4'h0, {3'h0, reg_state_out});
        // bus read through the vertical tap
        @(posedge ref_clk_in);
        rst_src_sel_in <= SRC_ONE; func_state_in <= FUNC_PASS; first_sel_in <= 4;
        tap_sel_in <= TAP_VERT; bus_read_en_in <= 4'h1; ext_oe <= 4'h1; ext_val <= 0;
        tick(2);
        chk("read low", 4'h0, first_class_out);
        @(posedge ref_clk_in); ext_val <= 4'h1;
        tick(2);
        chk("read high", 4'hF, first_class_out);
        // write, dynamic tristate, then a conflicting read
        @(posedge ref_clk_in);
        tap_sel_in <= TAP_ONE; bus_read_en_in <= 0;
        bus_write_en_in <= 4'h2; driver_pass_en_in <= 4'h2;
        tick(2);
        chk("write", 4'h2, bus_oe_out & bus_out);
        @(posedge ref_clk_in); drive_mode_in <= DRV_DYNAMIC; second_sel_in <= 0;
        tick(2);
        chk("dyn off", 4'h0, bus_oe_out);
        @(posedge ref_clk_in); second_class_in <= 4'h1;
        tick(2);
        chk("dyn on", 4'h2, bus_oe_out);
        @(posedge ref_clk_in); bus_read_en_in <= 4'h2;
        tick(2);
        chk("fault", 4'h2, bus_fault_out);
        chk("fault oe", 4'h0, bus_oe_out);
        // turn, repeater and corner feed
        @(posedge ref_clk_in);
        bus_read_en_in <= 0; bus_write_en_in <= 0; turn_en_in <= 2'h1;
        rep_func_in[0] <= 5'h01; global_clock_level_in <= 1;
        tick(3);
        chk("turn", 4'h2, bus_oe_out & bus_out);
        chk("repeater", 4'h1, seg_b_oe_out & seg_b_out);
        chk("corner", 4'h3, {2'h0, corner_west_first_input_out,
            corner_north_first_input_out});
        // repeater transfers, bidirectional link and reverse turn
        @(posedge ref_clk_in);
        rep_func_in[0] <= 5'h10; rep_func_in[1] <= 5'h0F; exp_a_in <= 4'h2; exp_b_in <= 4'h1;
        seg_b_in <= 4'h5; seg_b_active_in <= 4'h4; rep_bidir_en_in <= 4'h4;
        turn_dir_in <= 2'h1; ext_oe <= 4'h2; ext_val <= 4'h2;
        tick(3);
        chk("rep local", 4'h5, rep_local_oe_out & rep_local_out);
        chk("rep exp a", 4'h1, exp_a_oe_out & exp_a_out);
        chk("rep exp b", 4'h2, exp_b_oe_out & exp_b_out);
        chk("rep seg b", 4'h2, seg_b_oe_out & seg_b_out);
        chk("turn back", 4'h1, bus_oe_out & bus_out);
        // head-cell clock source and express column reset
        @(posedge ref_clk_in); clk_src_sel_in <= SRC_EDGE; second_class_in <= 4'h0;
        tick(2);
        chk("head low", 4'h0, {3'h0, reg_state_out});
        @(posedge ref_clk_in); head_first_in <= 1'h1;
        tick(2);
        chk("head edge", 4'h1, {3'h0, reg_state_out});
        @(posedge ref_clk_in); rst_src_sel_in <= SRC_EXPRESS; express_reset_n_in <= 1'h0;
        tick(2);
        chk("express reset", 4'h0, {3'h0, reg_state_out});
        tally_and_finish();
    end
endmodule : tb_top

/* inc/pac_pkg.sv */
// constants, encodings and the repeater function map of the array cell
// assumes one system clock; all configuration fields are static levels
package pac_pkg;

    localparam int NEIGH        = 4;     // north, south, east, west
    localparam int LOCAL_BUSES  = 4;     // vertical first, horizontal first, second pair
    localparam int SECTOR_CELLS = 8;     // cells between repeaters

    // operand selector: codes 0..3 pick a neighbour, this code picks constant one
    localparam logic [2:0] OPER_CONST_ONE = 3'h4;

    // three-input selector feeding the left upstream gate
    localparam logic [1:0] TAP_ONE  = 2'h0;
    localparam logic [1:0] TAP_VERT = 2'h1;
    localparam logic [1:0] TAP_HORZ = 2'h2;

    // shared function state of both output selectors
    localparam logic [1:0] FUNC_PASS     = 2'h0;
    localparam logic [1:0] FUNC_SWAP     = 2'h1;
    localparam logic [1:0] FUNC_XOR_NAND = 2'h2;
    localparam logic [1:0] FUNC_REG_AND  = 2'h3;

    // bus driver control selector
    localparam logic DRV_ACTIVE  = 1'h0;
    localparam logic DRV_DYNAMIC = 1'h1;

    // column clock and column reset source selectors
    localparam logic [1:0] SRC_GLOBAL  = 2'h0;
    localparam logic [1:0] SRC_EXPRESS = 2'h1;
    localparam logic [1:0] SRC_EDGE    = 2'h2;   // head cell (clock) or foot cell (reset)
    localparam logic [1:0] SRC_ONE     = 2'h3;

    // reset values
    localparam logic DFF_RESET = 1'h0;
    localparam logic OUT_RESET = 1'h0;

    // repeater: function code width, count and per-destination source codes
    localparam int         REP_FUNC_W  = 5;
    localparam logic [4:0] REP_FUNCS   = 5'h15;
    localparam logic [1:0] REP_NONE    = 2'h0;
    localparam logic [1:0] REP_LOCAL   = 2'h1;
    localparam logic [1:0] REP_EXPRESS = 2'h2;

    // per function: [7:6] side b local, [5:4] side b express,
    // [3:2] side a local, [1:0] side a express; source is always the far side
    localparam logic [20:0][7:0] REP_FUNC_MAP = {
        8'h81, 8'h18, 8'h24, 8'h42, 8'h09, 8'h90, 8'h06,
        8'h60, 8'h0A, 8'hA0, 8'h05, 8'h50, 8'h02, 8'h01,
        8'h08, 8'h04, 8'h20, 8'h10, 8'h80, 8'h40, 8'h00
    };

endpackage : pac_pkg

/* src/bus_repeater.sv */
// one repeater between two segments of a local/express bus pair
// assumes the far-side segment activity flags are synchronous levels
module bus_repeater
    import pac_pkg::*;
#(
    parameter logic HAS_BIDIR = 1'h0
) (
    input  wire logic                  ref_clk_in,
    input  wire logic                  nrst_in,
    input  wire logic [REP_FUNC_W-1:0] func_in,
    input  wire logic                  bidir_en_in,
    input  wire logic                  a_local_in,
    input  wire logic                  a_exp_in,
    input  wire logic                  b_local_in,
    input  wire logic                  b_exp_in,
    input  wire logic                  a_local_active_in,
    input  wire logic                  b_local_active_in,
    output logic      [3:0]            drive_val_out,   // [3] b local .. [0] a express
    output logic      [3:0]            drive_oe_out
);

    typedef struct packed {
        logic [3:0] val;
        logic [3:0] oe;
    } rep_state_t;

    rep_state_t q;
    rep_state_t next_q;
    logic [7:0] map;

    assign map = (func_in < REP_FUNCS) ? REP_FUNC_MAP[func_in] : 8'h00;

    // each destination regenerates one far-side source, one way only
    always_comb begin
        logic [1:0] code;
        logic       src_local;
        logic       src_exp;
        code      = REP_NONE;
        src_local = 1'h0;
        src_exp   = 1'h0;
        next_q    = q;
        for (int d = 0; d < 4; d++) begin
            code      = map[2*d +: 2];
            src_local = (d >= 2) ? a_local_in : b_local_in;
            src_exp   = (d >= 2) ? a_exp_in : b_exp_in;
            next_q.oe[d]  = (code != REP_NONE);
            next_q.val[d] = (code == REP_LOCAL) ? src_local :
                            (code == REP_EXPRESS) ? src_exp : 1'h0;
        end
        if (HAS_BIDIR && bidir_en_in) begin
            if (a_local_active_in && !b_local_active_in) begin
                next_q.oe[3]  = 1'h1;
                next_q.val[3] = a_local_in;
            end else if (b_local_active_in && !a_local_active_in) begin
                next_q.oe[1]  = 1'h1;
                next_q.val[1] = b_local_in;
            end
        end
        if (!nrst_in) begin
            next_q = '0;
        end
    end

    // state register
    always_ff @(posedge ref_clk_in) begin
        q <= next_q;
    end

    assign drive_val_out = q.val;
    assign drive_oe_out  = q.oe;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    AST_REP_ISOLATE: assert property ((func_in == 5'h00) && !bidir_en_in |=>
        (drive_oe_out == 4'h0)) else $error("isolate function drives a segment");
    AST_REP_ONE_WAY: assert property (nrst_in && (func_in == 5'h01) && !bidir_en_in |=>
        (drive_val_out[3] == $past(a_local_in)) && (drive_oe_out == 4'h8))
        else $error("local join is not one-way regenerated");

endmodule : bus_repeater

/* src/programmable_array_cell.sv */
// array logic cell with its bus repeaters and column clock/reset selection
// assumes all inputs synchronous to ref_clk_in; the bench resolves bus wires
// from the value and enable outputs

module programmable_array_cell
    import pac_pkg::*;
#(
    parameter int COL_POS = SECTOR_CELLS - 1,
    parameter int ROW_POS = SECTOR_CELLS - 1
) (
    input  wire logic                       ref_clk_in,
    input  wire logic                       nrst_in,
    input  wire logic [NEIGH-1:0]           first_class_in,
    input  wire logic [NEIGH-1:0]           second_class_in,
    input  wire logic [2:0]                 first_sel_in,
    input  wire logic [2:0]                 second_sel_in,
    input  wire logic [1:0]                 tap_sel_in,
    input  wire logic [1:0]                 func_state_in,
    input  wire logic [LOCAL_BUSES-1:0]     bus_in,
    input  wire logic [LOCAL_BUSES-1:0]     bus_read_en_in,
    input  wire logic [LOCAL_BUSES-1:0]     bus_write_en_in,
    input  wire logic [LOCAL_BUSES-1:0]     driver_pass_en_in,
    input  wire logic                       drive_mode_in,
    input  wire logic [1:0]                 turn_en_in,
    input  wire logic [1:0]                 turn_dir_in,
    input  wire logic [1:0]                 clk_src_sel_in,
    input  wire logic                       global_clock_level_in,
    input  wire logic                       express_clock_in,
    input  wire logic                       head_first_in,
    input  wire logic [1:0]                 rst_src_sel_in,
    input  wire logic                       global_reset_n_in,
    input  wire logic                       express_reset_n_in,
    input  wire logic                       foot_first_n_in,
    input  wire logic [LOCAL_BUSES-1:0][4:0] rep_func_in,
    input  wire logic [LOCAL_BUSES-1:0]     rep_bidir_en_in,
    input  wire logic [LOCAL_BUSES-1:0]     exp_a_in,
    input  wire logic [LOCAL_BUSES-1:0]     exp_b_in,
    input  wire logic [LOCAL_BUSES-1:0]     seg_b_in,
    input  wire logic [LOCAL_BUSES-1:0]     seg_b_active_in,
    output logic      [NEIGH-1:0]           first_class_out,
    output logic      [NEIGH-1:0]           second_class_out,
    output logic      [LOCAL_BUSES-1:0]     bus_out,
    output logic      [LOCAL_BUSES-1:0]     bus_oe_out,
    output logic      [LOCAL_BUSES-1:0]     bus_fault_out,
    output logic                            reg_state_out,
    output logic                            corner_west_first_input_out,
    output logic                            corner_north_first_input_out,
    output logic      [LOCAL_BUSES-1:0]     rep_local_out,
    output logic      [LOCAL_BUSES-1:0]     rep_local_oe_out,
    output logic      [LOCAL_BUSES-1:0]     seg_b_out,
    output logic      [LOCAL_BUSES-1:0]     seg_b_oe_out,
    output logic      [LOCAL_BUSES-1:0]     exp_a_out,
    output logic      [LOCAL_BUSES-1:0]     exp_a_oe_out,
    output logic      [LOCAL_BUSES-1:0]     exp_b_out,
    output logic      [LOCAL_BUSES-1:0]     exp_b_oe_out
);

    typedef struct packed {
        logic                   first_out;
        logic                   second_out;
        logic                   dff;
        logic                   src_prev;
        logic                   corner;
        logic [LOCAL_BUSES-1:0] bus_val;
        logic [LOCAL_BUSES-1:0] bus_oe;
        logic [LOCAL_BUSES-1:0] bus_fault;
    } cell_state_t;

    cell_state_t            q;
    cell_state_t            next_q;
    logic                   first_op;
    logic                   second_op;
    logic                   cell_vertical_bus_tap;
    logic                   horz_tap;
    logic                   tap;
    logic                   left_and;
    logic                   right_and;
    logic                   xor_v;
    logic                   a_next;
    logic                   b_next;
    logic                   drv_enable;
    logic                   src_level;
    logic                   col_tick;
    logic                   col_rst;
    logic [LOCAL_BUSES-1:0] rd;
    logic [LOCAL_BUSES-1:0] wr;
    logic [LOCAL_BUSES-1:0] tn;
    logic [LOCAL_BUSES-1:0] fault;
    logic [LOCAL_BUSES-1:0] rd_ok;
    logic [LOCAL_BUSES-1:0] turn_dest;
    logic [LOCAL_BUSES-1:0] drv_val;
    logic [LOCAL_BUSES-1:0] drv_oe;

    assign first_op  = (first_sel_in < OPER_CONST_ONE) ? first_class_in[first_sel_in[1:0]] : 1'h1;
    assign second_op = (second_sel_in < OPER_CONST_ONE) ? second_class_in[second_sel_in[1:0]]
                                                        : 1'h1;

    // per-bus operation decode
    assign rd = bus_read_en_in;
    // both pass gates for a write
    assign wr = bus_write_en_in & driver_pass_en_in;
    assign tn = {turn_en_in[1], turn_en_in[1], turn_en_in[0], turn_en_in[0]};
    assign fault = (rd & wr) | (rd & tn) | (wr & tn);
    assign rd_ok = rd & ~fault;

    // read taps through pass gates and tap selector
    assign cell_vertical_bus_tap = (rd_ok[0] & bus_in[0]) | (rd_ok[2] & bus_in[2]);
    assign horz_tap              = (rd_ok[1] & bus_in[1]) | (rd_ok[3] & bus_in[3]);
    assign tap = (tap_sel_in == TAP_VERT) ? cell_vertical_bus_tap :
                 (tap_sel_in == TAP_HORZ) ? horz_tap : 1'h1;

    // upstream gates
    assign left_and  = first_op & tap;
    assign right_and = second_op;
    assign xor_v     = left_and ^ right_and;

    assign drv_enable = (drive_mode_in == DRV_ACTIVE) | second_op;

    // per-bus write and turn drive
    generate
        for (genvar i = 0; i < LOCAL_BUSES; i++) begin : g_bus
            localparam int  PARTNER = i ^ 1;
            localparam logic IS_H   = (i % 2 == 1);
            // turn between paired buses
            // direction 0 lands on the horizontal bus, direction 1 on the vertical one
            assign turn_dest[i] = tn[i] & (turn_dir_in[i/2] ^ IS_H);
            assign drv_oe[i]    = ~fault[i] & ((wr[i] & drv_enable) | turn_dest[i]);
            assign drv_val[i]   = turn_dest[i] ? bus_in[PARTNER] : a_next;
        end
    endgenerate

    assign src_level = (clk_src_sel_in == SRC_EXPRESS) ? express_clock_in :
                       (clk_src_sel_in == SRC_EDGE) ? head_first_in : 1'h0;
    assign col_tick = (clk_src_sel_in == SRC_GLOBAL) ? 1'h1 :
                      (clk_src_sel_in == SRC_ONE) ? 1'h0 : (src_level & ~q.src_prev);
    assign col_rst = (rst_src_sel_in == SRC_GLOBAL) ? ~global_reset_n_in :
                     (rst_src_sel_in == SRC_EXPRESS) ? ~express_reset_n_in :
                     (rst_src_sel_in == SRC_EDGE) ? ~foot_first_n_in : 1'h0;

    // next state of the cell
    always_comb begin
        next_q          = q;
        next_q.src_prev = src_level;
        // flop driven by column tick and reset
        if (col_rst) begin
            next_q.dff = DFF_RESET;
        end else if (col_tick) begin
            next_q.dff = xor_v;
        end
        // one shared state for both selectors
        case (func_state_in)
            FUNC_PASS: begin
                a_next = left_and;
                b_next = right_and;
            end
            FUNC_SWAP: begin
                a_next = right_and;
                b_next = left_and;
            end
            FUNC_XOR_NAND: begin
                a_next = xor_v;
                b_next = ~(left_and & right_and);
            end
            FUNC_REG_AND: begin
                a_next = next_q.dff;
                b_next = left_and & right_and;
            end
            default: begin
                a_next = left_and;
                b_next = right_and;
            end
        endcase
        next_q.first_out  = a_next;
        next_q.second_out = b_next;
        next_q.bus_val    = drv_val;
        next_q.bus_oe     = drv_oe;
        next_q.bus_fault  = fault;
        next_q.corner     = global_clock_level_in;
        if (!nrst_in) begin
            next_q = '0;
            next_q.first_out  = OUT_RESET;
            next_q.second_out = OUT_RESET;
            next_q.dff        = DFF_RESET;
            // keep edge history so a source already high gives no false tick
            next_q.src_prev   = src_level;
        end
    end

    // state register
    always_ff @(posedge ref_clk_in) begin
        q <= next_q;
    end

    // outputs fan out to every neighbour
    generate
        for (genvar n = 0; n < NEIGH; n++) begin : g_neigh
            assign first_class_out[n]  = q.first_out;
            assign second_class_out[n] = q.second_out;
        end
    endgenerate

    assign bus_out                      = q.bus_val;
    assign bus_oe_out                   = q.bus_oe;
    assign bus_fault_out                = q.bus_fault;
    assign reg_state_out                = q.dff;
    assign corner_west_first_input_out  = q.corner;
    assign corner_north_first_input_out = q.corner;

    generate
        for (genvar r = 0; r < LOCAL_BUSES; r++) begin : g_rep
            localparam int POS = (r % 2 == 0) ? ROW_POS : COL_POS;
            if (POS % SECTOR_CELLS == SECTOR_CELLS - 1) begin : g_here
                logic [3:0] val;
                logic [3:0] oe;
                // bidirectional link on second buses only
                bus_repeater #(
                    .HAS_BIDIR (r >= 2)
                ) u_rep (
                    .ref_clk_in        (ref_clk_in),
                    .nrst_in           (nrst_in),
                    .func_in           (rep_func_in[r]),
                    .bidir_en_in       (rep_bidir_en_in[r]),
                    .a_local_in        (bus_in[r]),
                    .a_exp_in          (exp_a_in[r]),
                    .b_local_in        (seg_b_in[r]),
                    .b_exp_in          (exp_b_in[r]),
                    .a_local_active_in (q.bus_oe[r]),
                    .b_local_active_in (seg_b_active_in[r]),
                    .drive_val_out     (val),
                    .drive_oe_out      (oe)
                );
                assign seg_b_out[r]        = val[3];
                assign seg_b_oe_out[r]     = oe[3];
                assign exp_b_out[r]        = val[2];
                assign exp_b_oe_out[r]     = oe[2];
                assign rep_local_out[r]    = val[1];
                assign rep_local_oe_out[r] = oe[1];
                assign exp_a_out[r]        = val[0];
                assign exp_a_oe_out[r]     = oe[0];
            end else begin : g_none
                assign seg_b_out[r]        = 1'h0;
                assign seg_b_oe_out[r]     = 1'h0;
                assign exp_b_out[r]        = 1'h0;
                assign exp_b_oe_out[r]     = 1'h0;
                assign rep_local_out[r]    = 1'h0;
                assign rep_local_oe_out[r] = 1'h0;
                assign exp_a_out[r]        = 1'h0;
                assign exp_a_oe_out[r]     = 1'h0;
            end
        end
    endgenerate

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_express_rise;
        (clk_src_sel_in == SRC_EXPRESS) && !express_clock_in
        ##1 (clk_src_sel_in == SRC_EXPRESS) && express_clock_in && !col_rst && nrst_in;
    endsequence

    AST_OPERAND_ONE: assert property (nrst_in && (first_sel_in == OPER_CONST_ONE) &&
        (tap_sel_in == TAP_ONE) && (func_state_in == FUNC_PASS) |=> first_class_out[0])
        else $error("constant one operand not passed");
    AST_STATE0: assert property (nrst_in && (func_state_in == FUNC_PASS) |=>
        (q.first_out == $past(left_and)) && (q.second_out == $past(right_and)))
        else $error("state 0 routing wrong");
    AST_STATE1: assert property (nrst_in && (func_state_in == FUNC_SWAP) |=>
        (q.first_out == $past(right_and)) && (q.second_out == $past(left_and)))
        else $error("state 1 routing wrong");
    AST_STATE2: assert property (nrst_in && (func_state_in == FUNC_XOR_NAND) |=>
        (q.first_out == $past(xor_v)) && (q.second_out == !$past(left_and & right_and)))
        else $error("state 2 outputs wrong");
    AST_STATE3: assert property (nrst_in && (func_state_in == FUNC_REG_AND) |=>
        (q.first_out == q.dff) && (q.second_out == $past(left_and & right_and)))
        else $error("state 3 outputs wrong");
    AST_NO_CLOCK: assert property (nrst_in && (clk_src_sel_in == SRC_ONE) && !col_rst
        |=> $stable(q.dff)) else $error("register moved with clock stopped");
    AST_EXPRESS_EDGE: assert property (s_express_rise |=>
        (q.dff == $past(xor_v))) else $error("register missed express rising edge");
    AST_COL_RESET: assert property (col_rst |=> (q.dff == DFF_RESET))
        else $error("column reset did not clear register");
    AST_BUS_FAULT: assert property (##1 ((q.bus_oe & $past(fault)) == 4'h0))
        else $error("conflicting bus still driven");
    AST_WRITE_ACTIVE: assert property (wr[0] && !fault[0] && (drive_mode_in == DRV_ACTIVE)
        && nrst_in |=> bus_oe_out[0] && (bus_out[0] == q.first_out))
        else $error("bus write not driven");
    AST_CORNER: assert property (nrst_in |=> (corner_west_first_input_out ==
        $past(global_clock_level_in))) else $error("corner input not fed by global clock");

endmodule : programmable_array_cell
